// [dv/host_reader.sv]
// Host-side reader model for the delta output words
`timescale 1ns/1ns
module host_reader (
	// Clock
	input  wire logic                            clk,
	// Device read port
	output logic                                 regRead,
	output delta_angle_velocity_pkg::reg_addr_t  regAddr,
	input  wire logic                            regRdValid_r,
	input  wire delta_angle_velocity_pkg::word_t regRdData_r
);
	import delta_angle_velocity_pkg::*;

	initial
	begin
		regRead = 1'b0;
		regAddr = 7'h7f;
	end

	// Request held over one edge, answer taken in the following cycle
	task automatic rd16(input reg_addr_t a, output word_t d, output logic v);
		regRead = 1'b1;
		regAddr = a;
		@(posedge clk);
		#1;
		regRead = 1'b0;
		regAddr = ~a; // Idle address must not keep showing the last one
		d = regRdData_r;
		v = regRdValid_r;
		@(posedge clk);
		#1;
	endtask : rd16

	// Low then high; halves only agree if no update falls between them
	task automatic rd32(input reg_addr_t a, output out_t val, output logic ok);
		word_t lo;
		word_t hi;
		logic  v0;
		logic  v1;
		rd16(a, lo, v0);
		rd16(a + 7'h2, hi, v1);
		val = {hi, lo};
		ok = v0 & v1;
	endtask : rd32
endmodule : host_reader

// [dv/test_delta_angle_velocity_outputs.sv]
// Self-checking bench for the delta angle and velocity output stage
`timescale 1ns/1ns
module test_delta_angle_velocity_outputs;
	import delta_angle_velocity_pkg::*;

	localparam int PER = 8;

	logic               clk;
	logic               sysRst;
	logic signed [31:0] gX;
	logic signed [31:0] gY;
	logic signed [31:0] gZ;
	logic signed [31:0] aX;
	logic signed [31:0] aY;
	logic signed [31:0] aZ;
	word_t              dec;
	logic               regRead;
	reg_addr_t          regAddr;
	logic               rdValid;
	word_t              rdData;
	logic               tick;
	logic               ready;
	int                 n_fail;
	int                 tests_run;

	delta_angle_velocity_outputs #(.SAMPLE_PERIOD_CYC(PER), .RANGE(RANGE_360)) dut (
		.clk(clk), .sys_rst(sysRst), .gyroX(gX), .gyroY(gY), .gyroZ(gZ),
		.accelX(aX), .accelY(aY), .accelZ(aZ), .decimation_setting(dec),
		.regRead(regRead), .regAddr(regAddr), .regRdValid_r(rdValid), .regRdData_r(rdData),
		.sampleTick_r(tick), .sample_ready_output_r(ready)
	);

	host_reader host (
		.clk(clk), .regRead(regRead), .regAddr(regAddr), .regRdValid_r(rdValid), .regRdData_r(rdData)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic finish_test();
		$display("checks %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test

	// Cycles up to the next tick or ready pulse, bounded
	task automatic waitPulse(input logic selTick, output int c);
		c = 0;
		do
		begin
			@(posedge clk);
			#1;
			c++;
		end
		while ((selTick ? tick : ready) !== 1'b1 && c < 200);
		if (c >= 200)
			chk("pulseTimeout", 32'h0, 32'h1);
	endtask : waitPulse

	// Steady inputs: waits out three ready pulses, then reads all six results
	task automatic phase(input int gap, input out_t e[6]);
		int   c;
		out_t v;
		logic ok;
		repeat (3) waitPulse(1'b0, c);
		chk("readyGap", 32'(gap), 32'(c));
		for (int i = 0; i < 6; i++)
		begin
			host.rd32(7'h24 + 7'(4 * i), v, ok);
			chk("readValid", 32'h1, {31'h0, ok});
			chk($sformatf("word%0h", 7'h24 + 4 * i), e[i], v);
		end
	endtask : phase

	initial
	begin
		int    c;
		word_t d;
		logic  v;
		n_fail = 0;
		tests_run = 0;
		sysRst = 1'b1;
		dec = 16'h0000;
		gX = 32'h3;
		gY = 32'h64;
		gZ = -32'sh7;
		aX = 32'h12345678;
		aY = -32'sh2;
		aZ = 32'h9;
		repeat (4) @(posedge clk);
		#1;
		sysRst = 1'b0;
		host.rd16(7'h2a, d, v);
		chk("resetWord", 32'h0, {16'h0, d});
		waitPulse(1'b1, c);
		waitPulse(1'b1, c);
		chk("tickGap", 32'(PER), 32'(c));
		phase(PER, '{32'h12, 32'h258, 32'hffffffd6, 32'h12345678, 32'hfffffffe, 32'h9});
		dec = 16'h0003;
		phase(4 * PER, '{32'h48, 32'h960, 32'hffffff58, 32'h48d159e0, 32'hfffffff8, 32'h24});
		dec = 16'h0000;
		gY = 32'h40000000;
		gZ = 32'sh80000000;
		phase(PER, '{32'h12, 32'h7fffffff, 32'h80000000, 32'h12345678, 32'hfffffffe, 32'h9});
		host.rd16(7'h2b, d, v);
		chk("oddAddr", 32'h7fff, {16'h0, d});
		host.rd16(7'h40, d, v);
		chk("unmapped", 32'h0, {16'h0, d});
		chk("unmappedValid", 32'h1, {31'h0, v});
		finish_test();
	end

	initial
	begin
		#100000;
		chk("watchdog", 32'h0, 32'h1);
		finish_test();
	end
endmodule : test_delta_angle_velocity_outputs

// [hw/delta_angle_velocity_defines.svh]
// Register offsets, timing figures and scaling constants of the delta angle and velocity outputs
`ifndef DELTA_ANGLE_VELOCITY_DEFINES_SVH
`define DELTA_ANGLE_VELOCITY_DEFINES_SVH

`define X_ANGLE_CHANGE_LOW     7'h24
`define X_ANGLE_CHANGE_HIGH    7'h26
`define Y_ANGLE_CHANGE_LOW     7'h28
`define Y_ANGLE_CHANGE_HIGH    7'h2a
`define Z_ANGLE_CHANGE_LOW     7'h2c
`define Z_ANGLE_CHANGE_HIGH    7'h2e
`define X_VELOCITY_CHANGE_LOW  7'h30
`define X_VELOCITY_CHANGE_HIGH 7'h32
`define Y_VELOCITY_CHANGE_LOW  7'h34
`define Y_VELOCITY_CHANGE_HIGH 7'h36
`define Z_VELOCITY_CHANGE_LOW  7'h38
`define Z_VELOCITY_CHANGE_HIGH 7'h3a

`define CLK_RATE_HZ            100000000
`define SAMPLE_RATE_SPS        2000
`define SAMPLE_PERIOD_CYC      (`CLK_RATE_HZ / `SAMPLE_RATE_SPS)

`define ANGLE_GAIN_360         3'h6
`define ANGLE_GAIN_720         3'h3
`define ANGLE_GAIN_2160        3'h1
`define VELOCITY_GAIN          3'h1
`define HALF_SHIFT             1

`define OUT_MAX                32'h7fffffff
`define OUT_MIN                32'h80000000
`define WORD_RESET             16'h0000
`define OUT_RESET              32'h00000000
`define DEC_RESET              16'h0000

`define NUM_CHAN               6
`define NUM_ANGLE_CHAN         3

`endif

// [hw/delta_angle_velocity_outputs.sv]
// Delta angle and delta velocity integration with read-only paired output words
`timescale 1ns/1ns
`include "delta_angle_velocity_defines.svh"

module delta_angle_velocity_outputs #(
	parameter int                                    SAMPLE_W          = 32,
	parameter int                                    ACC_W             = 56,
	parameter int                                    SAMPLE_PERIOD_CYC = `SAMPLE_PERIOD_CYC,
	parameter delta_angle_velocity_pkg::angle_range_e RANGE            = delta_angle_velocity_pkg::RANGE_360
) (
	// Clock and reset
	input  wire logic                            clk,
	input  wire logic                            sys_rst,
	// Calibrated sensor samples, same clock domain
	input  wire logic signed [SAMPLE_W-1:0]      gyroX,
	input  wire logic signed [SAMPLE_W-1:0]      gyroY,
	input  wire logic signed [SAMPLE_W-1:0]      gyroZ,
	input  wire logic signed [SAMPLE_W-1:0]      accelX,
	input  wire logic signed [SAMPLE_W-1:0]      accelY,
	input  wire logic signed [SAMPLE_W-1:0]      accelZ,
	// Decimation from the control block
	input  wire delta_angle_velocity_pkg::word_t decimation_setting,
	// Register read port
	input  wire logic                            regRead,
	input  wire delta_angle_velocity_pkg::reg_addr_t regAddr,
	output logic                                 regRdValid_r,
	output delta_angle_velocity_pkg::word_t      regRdData_r,
	// Timing outputs
	output logic                                 sampleTick_r,
	output logic                                 sample_ready_output_r
);
	import delta_angle_velocity_pkg::*;

	localparam int TICK_W = $clog2(SAMPLE_PERIOD_CYC);

	function automatic logic [2:0] angleGain(input angle_range_e r);
		case (r)
			RANGE_360:  angleGain = `ANGLE_GAIN_360;
			RANGE_720:  angleGain = `ANGLE_GAIN_720;
			RANGE_2160: angleGain = `ANGLE_GAIN_2160;
			default:    angleGain = `ANGLE_GAIN_360;
		endcase
	endfunction : angleGain

	// Halving stands in for the 2 of 1/(2fs); 1/fs is carried by the sample scaling
	function automatic out_t scaleSat(input logic signed [ACC_W-1:0] a, input logic [2:0] g);
		logic signed [ACC_W+3:0] p;
		p = (a * $signed({1'b0, g})) >>> `HALF_SHIFT;
		if (!p[ACC_W+3] && (|p[ACC_W+3:31]))
			scaleSat = `OUT_MAX;
		else if (p[ACC_W+3] && !(&p[ACC_W+3:31]))
			scaleSat = `OUT_MIN;
		else
			scaleSat = p[31:0];
	endfunction : scaleSat

	function automatic logic [2:0] chanGain(input int i);
		chanGain = (i < `NUM_ANGLE_CHAN) ? angleGain(RANGE) : `VELOCITY_GAIN;
	endfunction : chanGain

	logic        [TICK_W-1:0]   tickCnt_r;
	logic        [15:0]         sampleCnt_r;
	logic                       lastSample;
	logic signed [SAMPLE_W-1:0] sampleIn   [`NUM_CHAN];
	logic signed [SAMPLE_W-1:0] prevSample_r [`NUM_CHAN];
	logic signed [ACC_W-1:0]    acc_r      [`NUM_CHAN];
	logic signed [ACC_W-1:0]    accNxt     [`NUM_CHAN];
	out_t                       outWord_r  [`NUM_CHAN];
	out_t                       outWordNxt [`NUM_CHAN];
	word_t                      rdData_nxt;

	assign sampleIn[0] = gyroX;
	assign sampleIn[1] = gyroY;
	assign sampleIn[2] = gyroZ;
	assign sampleIn[3] = accelX;
	assign sampleIn[4] = accelY;
	assign sampleIn[5] = accelZ;

	// Internal sample clock derived from clk
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			tickCnt_r    <= '0;
			sampleTick_r <= 1'b0;
		end
		else if (tickCnt_r == TICK_W'(SAMPLE_PERIOD_CYC - 1))
		begin
			tickCnt_r    <= '0;
			sampleTick_r <= 1'b1;
		end
		else
		begin
			tickCnt_r    <= tickCnt_r + 1'b1;
			sampleTick_r <= 1'b0;
		end
	end

	// Lowering the decimation mid-period ends the period at once rather than wrapping 16 bits
	assign lastSample = (sampleCnt_r >= decimation_setting);

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			sampleCnt_r <= `DEC_RESET;
		else if (sampleTick_r)
			sampleCnt_r <= lastSample ? `DEC_RESET : sampleCnt_r + 1'b1;
	end

	always_comb
	begin
		for (int i = 0; i < `NUM_CHAN; i++)
		begin
			accNxt[i]     = acc_r[i] + ACC_W'(sampleIn[i]) + ACC_W'(prevSample_r[i]);
			outWordNxt[i] = scaleSat(accNxt[i], chanGain(i));
		end
	end

	// Trapezoid sums over one output period
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < `NUM_CHAN; i++)
			begin
				prevSample_r[i] <= '0;
				acc_r[i]        <= '0;
			end
		end
		else if (sampleTick_r)
		begin
			for (int i = 0; i < `NUM_CHAN; i++)
			begin
				prevSample_r[i] <= sampleIn[i];
				acc_r[i]        <= lastSample ? '0 : accNxt[i];
			end
		end
	end

	// All twelve words load in one edge; a low/high pair read across that edge still mixes two periods
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			for (int i = 0; i < `NUM_CHAN; i++)
				outWord_r[i] <= `OUT_RESET;
			sample_ready_output_r <= 1'b0;
		end
		else
		begin
			sample_ready_output_r <= sampleTick_r && lastSample;
			if (sampleTick_r && lastSample)
				for (int i = 0; i < `NUM_CHAN; i++)
					outWord_r[i] <= outWordNxt[i];
		end
	end

	always_comb
	begin
		case ({regAddr[6:1], 1'b0})
			`X_ANGLE_CHANGE_LOW:     rdData_nxt = outWord_r[0][15:0];
			`X_ANGLE_CHANGE_HIGH:    rdData_nxt = outWord_r[0][31:16];
			`Y_ANGLE_CHANGE_LOW:     rdData_nxt = outWord_r[1][15:0];
			`Y_ANGLE_CHANGE_HIGH:    rdData_nxt = outWord_r[1][31:16];
			`Z_ANGLE_CHANGE_LOW:     rdData_nxt = outWord_r[2][15:0];
			`Z_ANGLE_CHANGE_HIGH:    rdData_nxt = outWord_r[2][31:16];
			`X_VELOCITY_CHANGE_LOW:  rdData_nxt = outWord_r[3][15:0];
			`X_VELOCITY_CHANGE_HIGH: rdData_nxt = outWord_r[3][31:16];
			`Y_VELOCITY_CHANGE_LOW:  rdData_nxt = outWord_r[4][15:0];
			`Y_VELOCITY_CHANGE_HIGH: rdData_nxt = outWord_r[4][31:16];
			`Z_VELOCITY_CHANGE_LOW:  rdData_nxt = outWord_r[5][15:0];
			`Z_VELOCITY_CHANGE_HIGH: rdData_nxt = outWord_r[5][31:16];
			default:                 rdData_nxt = `WORD_RESET;
		endcase
	end

	// Read-only: there is no write path at all
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			regRdValid_r <= 1'b0;
			regRdData_r  <= `WORD_RESET;
		end
		else
		begin
			regRdValid_r <= regRead;
			if (regRead)
				regRdData_r <= rdData_nxt;
		end
	end

	// Helper view of the checked channel sums
	out_t expAngY;
	out_t expVelX;
	assign expAngY = scaleSat(accNxt[1], angleGain(RANGE));
	assign expVelX = scaleSat(accNxt[3], `VELOCITY_GAIN);

	sequence s_period_end;
		sampleTick_r && lastSample;
	endsequence

	sequence s_mid_tick;
		sampleTick_r && !lastSample;
	endsequence

	a_tick_spacing: assert property (@(posedge clk) disable iff (sys_rst)
		sampleTick_r |-> (tickCnt_r == '0) ##1 !sampleTick_r)
		else $error("sample tick not on period boundary");

	a_ready_single: assert property (@(posedge clk) disable iff (sys_rst)
		sample_ready_output_r |=> !sample_ready_output_r)
		else $error("ready pulse longer than one cycle");

	a_ready_cause: assert property (@(posedge clk) disable iff (sys_rst)
		sample_ready_output_r |-> $past(sampleTick_r) && $past(sampleCnt_r >= decimation_setting))
		else $error("ready without completed period");

	a_angle_result: assert property (@(posedge clk) disable iff (sys_rst)
		s_period_end |=> outWord_r[1] == $past(expAngY))
		else $error("y angle result mismatch");

	a_velocity_result: assert property (@(posedge clk) disable iff (sys_rst)
		s_period_end |=> outWord_r[3] == $past(expVelX))
		else $error("x velocity result mismatch");

	a_words_hold: assert property (@(posedge clk) disable iff (sys_rst)
		!(sampleTick_r && lastSample) |=> $stable(outWord_r[2]) && $stable(outWord_r[4]))
		else $error("output words changed outside update");

	a_acc_clear: assert property (@(posedge clk) disable iff (sys_rst)
		s_period_end |=> acc_r[0] == '0 && sampleCnt_r == `DEC_RESET)
		else $error("accumulator not cleared at period end");

	a_count_step: assert property (@(posedge clk) disable iff (sys_rst)
		s_mid_tick |=> sampleCnt_r == $past(sampleCnt_r) + 16'h0001)
		else $error("sample count did not advance");

	a_prev_track: assert property (@(posedge clk) disable iff (sys_rst)
		sampleTick_r |=> prevSample_r[4] == $past(accelY))
		else $error("predecessor sample not kept");

	a_read_high: assert property (@(posedge clk) disable iff (sys_rst)
		regRead && regAddr == `Y_ANGLE_CHANGE_HIGH && !(sampleTick_r && lastSample)
			|=> regRdValid_r && regRdData_r == outWord_r[1][31:16])
		else $error("y angle high word read wrong");

	a_read_unmapped: assert property (@(posedge clk) disable iff (sys_rst)
		regRead && regAddr > `Z_VELOCITY_CHANGE_HIGH + 7'h01 |=> regRdData_r == `WORD_RESET)
		else $error("unmapped read not zero");

	a_sat_low: assert property (@(posedge clk) disable iff (sys_rst)
		s_period_end && accNxt[2] < 0 |=> outWord_r[2][31])
		else $error("negative angle lost its sign");

endmodule : delta_angle_velocity_outputs

// [hw/delta_angle_velocity_pkg.sv]
// Types shared by the delta angle and velocity output stage
package delta_angle_velocity_pkg;

	typedef logic [15:0] word_t;
	typedef logic [6:0]  reg_addr_t;
	typedef logic [31:0] out_t;

	typedef enum {
		RANGE_360,
		RANGE_720,
		RANGE_2160
	} angle_range_e;

endpackage : delta_angle_velocity_pkg
